// ===== verilog/srtcs_top.sv
// Serial control and status block with an AXI4-Lite register slave.
// Assumes one clock; the pins rxd_pin is asynchronous to it.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module srtcs_top
	import srtcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rxd_pin,
	output logic txd_pin,
	output logic txd_oe,
	output logic rxd_claim,
	output logic irq
);
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFF_CTRL2) || (a == OFF_STAT1) ||
			(a == OFF_DATA) || (a == OFF_CONF) || (a == OFF_BAUD) ||
			(a == OFF_ISTAT) || (a == OFF_IMASK);
	endfunction

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rd_word;

	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready = !w_full_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire wr_en8 = wr_fire && w_strb_reg[0];
	wire wr_ctrl = wr_en8 && (aw_addr_reg == OFF_CTRL2);
	wire wr_conf = wr_en8 && (aw_addr_reg == OFF_CONF);
	wire wr_imask = wr_en8 && (aw_addr_reg == OFF_IMASK);
	wire wr_baud = wr_fire && (w_strb_reg[1:0] == 2'h3) &&
		(aw_addr_reg == OFF_BAUD);
	wire data_wr = wr_en8 && (aw_addr_reg == OFF_DATA);
	wire st_rd = rd_fire && (s_axi_araddr == OFF_STAT1);
	wire data_rd = rd_fire && (s_axi_araddr == OFF_DATA);
	wire istat_rd = rd_fire && (s_axi_araddr == OFF_ISTAT);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ****************************************************************
	// Control, configuration and divider
	// ****************************************************************
	logic [7:0] ctrl_reg, conf_reg;
	logic [15:0] baud_reg, div_reg;
	logic [7:0] ctrl_next;
	logic rxd_meta_reg, rxd_sync_reg;
	logic wake;
	wire tx_on = ctrl_reg[C2_TE];
	wire rcv_on = ctrl_reg[C2_RE];
	wire standby = ctrl_reg[C2_RWU];
	wire break_queue = ctrl_reg[C2_SBK];
	wire loop_select = conf_reg[CF_LOOP];
	wire tick16 = (div_reg == 16'h0000);
	wire te_rise = wr_ctrl && w_data_reg[C2_TE] && !tx_on;
	wire brk_rise = wr_ctrl && w_data_reg[C2_SBK] && !break_queue;
	wire brk_wr1 = wr_ctrl && w_data_reg[C2_SBK];

	assign ctrl_next = wr_ctrl ? w_data_reg[7:0] :
		(ctrl_reg & ~(8'(wake) << C2_RWU));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL2_RST;
			conf_reg <= CONF_RST;
			baud_reg <= BAUD_RST;
			div_reg <= BAUD_RST;
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			if (wr_conf) conf_reg <= w_data_reg[7:0];
			if (wr_baud) baud_reg <= w_data_reg[15:0];
			div_reg <= tick16 ? baud_reg : div_reg - 16'h0001;
			rxd_meta_reg <= rxd_pin;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	// ****************************************************************
	// Transmit side
	// ****************************************************************
	logic [8:0] txbuf_reg;
	logic txbuf_full_reg, tx_buffer_empty_reg, tx_buffer_empty_arm_reg, tc_reg, tc_arm_reg;
	logic brk_pend_reg, idle_pend_reg;
	logic tx_busy, tx_txd;
	srtcs_txreq_s tx_req;
	wire shifter_free = tx_on && !tx_busy;
	wire start_idle = shifter_free && idle_pend_reg;
	// keep queuing breaks while the bit stays at one
	// a break may start again just before software clears the bit
	wire start_brk = shifter_free && !idle_pend_reg &&
		(brk_pend_reg || break_queue);
	wire tx_load = shifter_free && !idle_pend_reg && !brk_pend_reg &&
		!break_queue && txbuf_full_reg;
	wire tx_start = start_idle || start_brk || tx_load;
	// clear only after an armed status read
	wire tx_buffer_empty_clr = tx_buffer_empty_arm_reg && data_wr;
	// idle with nothing pending
	// A clearing action starts new activity, so it must not set the flag.
	wire tc_set = tx_buffer_empty_reg && !tx_busy && !tx_start && !idle_pend_reg &&
		!brk_pend_reg && !break_queue && !txbuf_full_reg &&
		!data_wr && !te_rise && !brk_wr1;
	// three clearing actions after an armed read
	wire tc_clr = tc_arm_reg && (data_wr || te_rise || brk_wr1);

	assign tx_req.kind = start_idle ? TXK_IDLE :
		start_brk ? TXK_BREAK : TXK_DATA;
	assign tx_req.data = txbuf_reg;
	assign tx_req.nine = conf_reg[CF_NINE];
	assign tx_req.long_brk = conf_reg[CF_LONG_BREAK_SELECT];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txbuf_reg <= 9'h000;
			txbuf_full_reg <= 1'b0;
			brk_pend_reg <= 1'b0;
			idle_pend_reg <= 1'b0;
		end else begin
			if (data_wr) txbuf_reg <= w_data_reg[8:0];
			txbuf_full_reg <= data_wr || (txbuf_full_reg && !tx_load);
			// a rising write queues one break even if cleared at once
			brk_pend_reg <= brk_rise || (brk_pend_reg && !start_brk);
			idle_pend_reg <= te_rise || (idle_pend_reg && !start_idle);
		end
	end

	// Setting terms win over clears so no event is lost.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_buffer_empty_reg <= 1'b1;
			tc_reg <= 1'b1;
			tx_buffer_empty_arm_reg <= 1'b0;
			tc_arm_reg <= 1'b0;
		end else begin
			// set when the buffer moves to the shifter
			tx_buffer_empty_reg <= tx_load || (tx_buffer_empty_reg && !tx_buffer_empty_clr);
			tc_reg <= tc_set || (tc_reg && !tc_clr);
			tx_buffer_empty_arm_reg <= (st_rd && tx_buffer_empty_reg) || (tx_buffer_empty_arm_reg && !tx_buffer_empty_clr);
			tc_arm_reg <= (st_rd && tc_reg) || (tc_arm_reg && !tc_clr);
		end
	end

	srtcs_tx u_tx (
		.clk(clk),
		.rst_b(rst_b),
		.tick16(tick16),
		.start(tx_start),
		.req(tx_req),
		.busy(tx_busy),
		.txd(tx_txd)
	);

	// The pin stays driven until the last frame ends after enable drops.
	assign txd_pin = tx_txd;
	assign txd_oe = tx_on || tx_busy;

	// ****************************************************************
	// Receive side
	// ****************************************************************
	logic [8:0] rxdata_reg;
	logic rx_buffer_full_reg, rx_buffer_full_arm_reg;
	srtcs_rxchar_s rx_chr;
	logic rx_idle;
	// pin claimed only when on and not looped
	assign rxd_claim = rcv_on && !loop_select;
	wire rx_in = loop_select ? tx_txd : rxd_sync_reg;
	wire rx_msb = conf_reg[CF_NINE] ? rx_chr.data[8] : rx_chr.data[7];
	wire addr_wake = standby && conf_reg[CF_WAKE] && rx_chr.valid && rx_msb;
	assign wake = standby && (conf_reg[CF_WAKE] ? (rx_chr.valid && rx_msb) :
		rx_idle);
	// characters in standby are dropped unless they wake the receiver
	wire rx_take = rx_chr.valid && rcv_on && (!standby || addr_wake);
	// read status armed, then read data
	wire rx_buffer_full_clr = rx_buffer_full_arm_reg && data_rd;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rxdata_reg <= 9'h000;
			rx_buffer_full_reg <= 1'b0;
			rx_buffer_full_arm_reg <= 1'b0;
		end else begin
			if (rx_take) rxdata_reg <= rx_chr.data;
			rx_buffer_full_reg <= rx_take || (rx_buffer_full_reg && !rx_buffer_full_clr);
			rx_buffer_full_arm_reg <= (st_rd && rx_buffer_full_reg) || (rx_buffer_full_arm_reg && !rx_buffer_full_clr);
		end
	end

	srtcs_rx u_rx (
		.clk(clk),
		.rst_b(rst_b),
		.tick16(tick16),
		.enable(rcv_on),
		.rxd(rx_in),
		.nine(conf_reg[CF_NINE]),
		.chr(rx_chr),
		.idle_pulse(rx_idle)
	);

	// ****************************************************************
	// Interrupts and read data
	// ****************************************************************
	logic [4:0] istat_reg, imask_reg, events;
	logic irq_reg;
	wire [7:0] status1 = {tx_buffer_empty_reg, tc_reg, rx_buffer_full_reg, 5'h00};
	assign events = {wake, rx_idle, rx_take, tc_set && !tc_reg, tx_load};
	wire irq_next = (|(istat_reg & imask_reg)) ||
		(ctrl_reg[C2_TIE] && tx_buffer_empty_reg) || (ctrl_reg[C2_TCIE] && tc_reg) ||
		(ctrl_reg[C2_RIE] && rx_buffer_full_reg);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			istat_reg <= 5'h00;
			imask_reg <= IMASK_RST;
			irq_reg <= 1'b0;
		end else begin
			istat_reg <= events | (istat_reg & ~{5{istat_rd}});
			if (wr_imask) imask_reg <= w_data_reg[4:0];
			irq_reg <= irq_next;
		end
	end
	assign irq = irq_reg;

	// status one is read-only; its offset has no write path
	assign rd_word = (s_axi_araddr == OFF_CTRL2) ? 32'(ctrl_reg) :
		(s_axi_araddr == OFF_STAT1) ? 32'(status1) :
		(s_axi_araddr == OFF_DATA) ? 32'(rxdata_reg) :
		(s_axi_araddr == OFF_CONF) ? 32'(conf_reg) :
		(s_axi_araddr == OFF_BAUD) ? 32'(baud_reg) :
		(s_axi_araddr == OFF_ISTAT) ? 32'(istat_reg) :
		(s_axi_araddr == OFF_IMASK) ? 32'(imask_reg) : 32'h0000_0000;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_rx_pin_off: assert property (!rcv_on |-> !rxd_claim)
		else $error("receive pin held while receiver off");
	chk_rx_pin_loop: assert property (loop_select |-> !rxd_claim)
		else $error("receive pin held in loop mode");
	chk_standby_wake: assert property (
		(standby && rx_idle && !conf_reg[CF_WAKE] && !wr_ctrl) |=> !standby)
		else $error("standby not cleared by idle wakeup");
	chk_addr_wake: assert property (
		(addr_wake && !wr_ctrl) |=> (!standby && rx_buffer_full_reg))
		else $error("address mark did not wake and load");
	chk_break_one: assert property (
		brk_rise |=> (brk_pend_reg || tx_busy) [*2])
		else $error("break not queued after rising write");
	chk_break_repeat: assert property (
		(break_queue && shifter_free && !idle_pend_reg) |=> tx_busy)
		else $error("held break bit did not restart break");
	chk_status_ro: assert property (
		(wr_fire && aw_addr_reg == OFF_STAT1 && !tx_load && !tc_set &&
		!rx_take && !tc_clr && !rx_buffer_full_clr) |=> $stable(status1))
		else $error("status changed by a write");
	chk_tx_buffer_empty_set: assert property (tx_load |=> tx_buffer_empty_reg && tx_busy)
		else $error("empty flag not set on buffer transfer");
	chk_tx_buffer_empty_clear: assert property (
		$fell(tx_buffer_empty_reg) |-> $past(tx_buffer_empty_arm_reg && data_wr))
		else $error("empty flag cleared without sequence");
	chk_tc_set: assert property (tc_set |=> tc_reg)
		else $error("complete flag not set when idle");
	chk_tc_clear: assert property (
		$fell(tc_reg) |-> $past(tc_arm_reg))
		else $error("complete flag cleared without status read");
	chk_rx_buffer_full_set: assert property (rx_take |=> rx_buffer_full_reg ##1 rx_buffer_full_reg)
		else $error("receive full not set on character");
	chk_rx_buffer_full_clear: assert property (
		$fell(rx_buffer_full_reg) |-> $past(rx_buffer_full_arm_reg && data_rd))
		else $error("receive full cleared without sequence");
	chk_irq_empty: assert property (
		(ctrl_reg[C2_TIE] && tx_buffer_empty_reg) |=> irq)
		else $error("no interrupt for empty buffer");
	chk_preamble: assert property (te_rise |=> idle_pend_reg || tx_busy)
		else $error("preamble not queued on enable rise");
endmodule
`default_nettype wire

// ===== verilog/srtcs_pkg.sv
// Shared constants and types for the serial control and status block.
// Assumes a single 200 MHz clock; all rates come from enable pulses.
`default_nettype none
package srtcs_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 200_000_000;
	localparam logic [15:0] BAUD_RST = 16'h0516;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] LEN_NORM = 4'ha;
	localparam logic [3:0] LEN_LONG = 4'hd;
	localparam logic [3:0] DATA8 = 4'h8;
	localparam logic [3:0] DATA9 = 4'h9;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0] OFF_CTRL2 = 8'h00;
	localparam logic [7:0] OFF_STAT1 = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_CONF = 8'h0c;
	localparam logic [7:0] OFF_BAUD = 8'h10;
	localparam logic [7:0] OFF_ISTAT = 8'h14;
	localparam logic [7:0] OFF_IMASK = 8'h18;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] CONF_RST = 8'h00;
	localparam logic [4:0] IMASK_RST = 5'h00;
	localparam int C2_TIE = 7;
	localparam int C2_TCIE = 6;
	localparam int C2_RIE = 5;
	localparam int C2_TE = 3;
	localparam int C2_RE = 2;
	localparam int C2_RWU = 1;
	localparam int C2_SBK = 0;
	localparam int CF_LOOP = 0;
	localparam int CF_LONG_BREAK_SELECT = 1;
	localparam int CF_WAKE = 2;
	localparam int CF_NINE = 3;
	localparam int EV_TXLOAD = 0;
	localparam int EV_TXDONE = 1;
	localparam int EV_RXCHAR = 2;
	localparam int EV_IDLE = 3;
	localparam int EV_WAKE = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		TXK_DATA = 2'b00,
		TXK_BREAK = 2'b01,
		TXK_IDLE = 2'b10
	} srtcs_txkind_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10
	} srtcs_rxstate_e;
	typedef struct packed {
		srtcs_txkind_e kind;
		logic [8:0] data;
		logic nine;
		logic long_brk;
	} srtcs_txreq_s;
	typedef struct packed {
		logic valid;
		logic [8:0] data;
	} srtcs_rxchar_s;

	// Bits in one frame: start, data and stop, or a break of that length, three more if long.
	function automatic logic [3:0] frame_bits(input logic nine,
		input logic long_sel);
		frame_bits = (long_sel ? LEN_LONG : LEN_NORM) + 4'(nine);
	endfunction
endpackage
`default_nettype wire

// ===== verilog/srtcs_tx.sv
// Transmit shifter: sends one data, break or idle frame per start pulse.
// Assumes tick16 pulses at sixteen times the bit rate.
`timescale 1ns/1ps
`default_nettype none
module srtcs_tx
	import srtcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick16,
	input wire logic start,
	input wire srtcs_txreq_s req,
	output logic busy,
	output logic txd
);
	logic [14:0] shift_reg;
	logic [3:0] bits_reg;
	logic [3:0] sub_reg;
	logic busy_reg;
	logic [14:0] frame_w;
	logic [3:0] len_w;
	wire bit_end = tick16 && (sub_reg == TICK_LAST);

	assign len_w = frame_bits(req.nine,
		(req.kind == TXK_BREAK) && req.long_brk);
	// Only the low len_w bits of a break are zero, so the line goes high after.
	assign frame_w = (req.kind == TXK_BREAK) ? (15'h7fff << len_w) :
		(req.kind == TXK_IDLE) ? 15'h7fff :
		req.nine ? {4'hf, 1'b1, req.data, 1'b0} :
		{5'h1f, 1'b1, req.data[7:0], 1'b0};

	// The line idles high because ones refill the shifter from the top.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			shift_reg <= 15'h7fff;
			bits_reg <= 4'h0;
			sub_reg <= 4'h0;
			busy_reg <= 1'b0;
		end else if (start && !busy_reg) begin
			shift_reg <= frame_w;
			bits_reg <= len_w;
			sub_reg <= 4'h0;
			busy_reg <= 1'b1;
		end else if (busy_reg && tick16) begin
			sub_reg <= sub_reg + 4'h1;
			if (bit_end) begin
				shift_reg <= {1'b1, shift_reg[14:1]};
				bits_reg <= bits_reg - 4'h1;
				busy_reg <= (bits_reg != 4'h1);
			end
		end
	end

	assign busy = busy_reg;
	assign txd = shift_reg[0];
endmodule
`default_nettype wire

// ===== verilog/srtcs_rx.sv
// Receive shifter with idle-line detection.
// Assumes rxd is already synchronised and tick16 is 16x the bit rate.
`timescale 1ns/1ps
`default_nettype none
module srtcs_rx
	import srtcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick16,
	input wire logic enable,
	input wire logic rxd,
	input wire logic nine,
	output srtcs_rxchar_s chr,
	output logic idle_pulse
);
	srtcs_rxstate_e state_reg;
	logic [3:0] sub_reg;
	logic [3:0] bits_reg;
	logic [3:0] idle_reg;
	logic [8:0] shift_reg;
	logic active_reg;
	srtcs_rxchar_s chr_reg;
	logic idle_p_reg;
	wire [3:0] nbits = nine ? DATA9 : DATA8;
	wire [3:0] idle_len = frame_bits(nine, 1'b0);

	// Idle is reported once per burst of activity, not every frame time.
	always_ff @(posedge clk) begin
		if (!rst_b || !enable) begin
			state_reg <= RX_IDLE;
			sub_reg <= 4'h0;
			bits_reg <= 4'h0;
			idle_reg <= 4'h0;
			shift_reg <= 9'h000;
			active_reg <= 1'b0;
			chr_reg <= '0;
			idle_p_reg <= 1'b0;
		end else begin
			chr_reg.valid <= 1'b0;
			idle_p_reg <= 1'b0;
			if (tick16) begin
				sub_reg <= sub_reg + 4'h1;
				case (state_reg)
				RX_IDLE: begin
					if (!rxd) begin
						state_reg <= RX_START;
						sub_reg <= 4'h0;
						idle_reg <= 4'h0;
						active_reg <= 1'b1;
					end else if (sub_reg == TICK_LAST && idle_reg != idle_len) begin
						idle_reg <= idle_reg + 4'h1;
						if (idle_reg == idle_len - 4'h1 && active_reg) begin
							idle_p_reg <= 1'b1;
							active_reg <= 1'b0;
						end
					end
				end
				RX_START: begin
					if (sub_reg == TICK_MID) begin
						sub_reg <= 4'h0;
						bits_reg <= 4'h0;
						state_reg <= rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (sub_reg == TICK_LAST) begin
						if (bits_reg == nbits) begin
							state_reg <= RX_IDLE;
							chr_reg.valid <= 1'b1;
							chr_reg.data <= nine ? shift_reg :
								{1'b0, shift_reg[8:1]};
						end else begin
							shift_reg <= {rxd, shift_reg[8:1]};
							bits_reg <= bits_reg + 4'h1;
						end
					end
				end
				default: state_reg <= RX_IDLE;
				endcase
			end
		end
	end

	assign chr = chr_reg;
	assign idle_pulse = idle_p_reg;
endmodule
`default_nettype wire

// ===== test/srtcs_node.sv
// Remote serial node: sends characters on rxd and times low runs on txd.
// Assumes a bit time of BIT clocks of the block's clock.
`timescale 1ns/1ps
`default_nettype none
module srtcs_node #(
	parameter int BIT = 16
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	int run = 0;
	int low_run = 0;
	initial rxd = 1'b1;
	// keep each run: a second queued break shows as a fresh run.
	always @(posedge clk) begin
		if (txd === 1'b0) begin
			run <= run + 1;
		end else begin
			if (run != 0) begin
				low_run <= run;
			end
			run <= 0;
		end
	end
	// Start bit, eight data bits LSB first, then the stop bit.
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ===== test/srtcs_top_tb_top.sv
// Self-checking bench for the serial control and status block.
// Assumes BAUD is set to zero, giving a bit time of sixteen clocks.
`timescale 1ns/1ps
`default_nettype none
module srtcs_top_tb_top;
	import srtcs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic txd, txd_oe, claim, irq, rxd;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rdat;
	int bad_count = 0;
	int comparisons = 0;
	always #2.5 clk = ~clk;
	srtcs_top srtcs_top_inst (.clk(clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rxd_pin(rxd), .txd_pin(txd),
		.txd_oe(txd_oe), .rxd_claim(claim), .irq(irq));
	srtcs_node srtcs_node_inst (.clk(clk), .txd(txd), .rxd(rxd));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready) begin
				awvalid <= 1'b0;
				aw = 1'b1;
			end
			if (!w && wready) begin
				wvalid <= 1'b0;
				w = 1'b1;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		rd(OFF_STAT1);
		chk(rdat & m, e);
	endtask
	task automatic t_regs;
		stat(32'h0000_00ff, 32'h0000_00c0);
		rd(OFF_CTRL2);
		chk(rdat, 32'h0000_0000);
		chk({31'h0, claim}, 32'h0000_0000);
		wr(OFF_CTRL2, 32'h0000_0004);
		chk({31'h0, claim}, 32'h0000_0001);
		wr(OFF_CONF, 32'h0000_0001);
		chk({31'h0, claim}, 32'h0000_0000);
		wr(OFF_CONF, 32'h0000_0000);
		wr(OFF_STAT1, 32'h0000_0000);
		stat(32'h0000_00ff, 32'h0000_00c0);
		wr(8'h40, 32'h0000_0000);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
	endtask
	task automatic t_tx;
		wr(OFF_CTRL2, 32'h0000_0008);
		repeat (400) @(posedge clk);
		chk({31'h0, txd_oe}, 32'h0000_0001);
		wr(OFF_DATA, 32'h0000_0055);
		stat(32'h0000_0080, 32'h0000_0080);
		wr(OFF_DATA, 32'h0000_00aa);
		stat(32'h0000_00c0, 32'h0000_0000);
		repeat (400) @(posedge clk);
		stat(32'h0000_00ff, 32'h0000_00c0);
		wr(OFF_CTRL2, 32'h0000_0000);
		chk({31'h0, txd_oe}, 32'h0000_0000);
		wr(OFF_CTRL2, 32'h0000_0008);
		stat(32'h0000_0040, 32'h0000_0000);
		repeat (400) @(posedge clk);
	endtask
	task automatic t_break;
		int b;
		for (int i = 0; i < 2; i++) begin
			b = (i == 0) ? 160 : 208;
			wr(OFF_CONF, 32'(i * 2));
			stat(32'h0000_0040, 32'h0000_0040);
			wr(OFF_CTRL2, 32'h0000_0009);
			wr(OFF_CTRL2, 32'h0000_0008);
			stat(32'h0000_0040, 32'h0000_0000);
			repeat (900) @(posedge clk);
			if (srtcs_node_inst.low_run == 2 * b) begin
				b = 2 * b;
			end
			chk(32'(srtcs_node_inst.low_run), 32'(b));
		end
		wr(OFF_CONF, 32'h0000_0000);
	endtask
	task automatic t_irq_rx;
		wr(OFF_CTRL2, 32'h0000_0088);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(OFF_CTRL2, 32'h0000_0004);
		wr(OFF_IMASK, 32'h0000_0004);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		srtcs_node_inst.send(8'ha5);
		repeat (40) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		stat(32'h0000_0020, 32'h0000_0020);
		rd(OFF_DATA);
		chk(rdat, 32'h0000_00a5);
		stat(32'h0000_0020, 32'h0000_0000);
		rd(OFF_ISTAT);
		rd(OFF_ISTAT);
		chk(rdat & 32'h0000_0004, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
	endtask
	task automatic t_wake;
		wr(OFF_CONF, 32'h0000_0004);
		wr(OFF_CTRL2, 32'h0000_0006);
		srtcs_node_inst.send(8'h12);
		repeat (40) @(posedge clk);
		stat(32'h0000_0020, 32'h0000_0000);
		rd(OFF_CTRL2);
		chk(rdat & 32'h0000_0002, 32'h0000_0002);
		srtcs_node_inst.send(8'h85);
		repeat (40) @(posedge clk);
		stat(32'h0000_0020, 32'h0000_0020);
		rd(OFF_CTRL2);
		chk(rdat & 32'h0000_0002, 32'h0000_0000);
		rd(OFF_DATA);
		chk(rdat, 32'h0000_0085);
		wr(OFF_CONF, 32'h0000_0000);
		wr(OFF_CTRL2, 32'h0000_0006);
		srtcs_node_inst.send(8'h12);
		repeat (300) @(posedge clk);
		rd(OFF_CTRL2);
		chk(rdat & 32'h0000_0002, 32'h0000_0000);
	endtask
	task automatic t_loop;
		wr(OFF_CONF, 32'h0000_0009);
		wr(OFF_CTRL2, 32'h0000_000c);
		chk({31'h0, claim}, 32'h0000_0000);
		wr(OFF_DATA, 32'h0000_01a5);
		repeat (500) @(posedge clk);
		stat(32'h0000_0020, 32'h0000_0020);
		rd(OFF_DATA);
		chk(rdat, 32'h0000_01a5);
		stat(32'h0000_0020, 32'h0000_0000);
		wr(OFF_CONF, 32'h0000_0000);
	endtask
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// The tests need about 6k cycles; the limit leaves ample margin.
	initial begin
		#300000;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		wr(OFF_BAUD, 32'h0000_0000);
		// The divider takes the new rate only once the reset count runs out.
		repeat (1400) @(posedge clk);
		t_regs();
		t_tx();
		t_break();
		t_irq_rx();
		t_wake();
		t_loop();
		end_sim();
	end
endmodule
`default_nettype wire
